// ### rtl/lsl_dev_end.sv
// Deserializer end: power-up hold-off, link lock tracking and control-channel registers.
// Assumes the host end on the same lsl_if, sharing clock and resetn.
`timescale 1ns/1ps
`default_nettype none
module lsl_dev_end #(
  parameter int POWERUP_CYC = lsl_pkg::POWERUP_CYCLES,
  parameter int LOCK_CYC = lsl_pkg::LOCK_ACQ_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  lsl_if.dev lnk,
  output lsl_pkg::lsl_state_e link_state,
  output logic deser_en,
  output logic [2:0] link_bits,
  output logic [7:0] misc_cfg,
  output logic lock_lost
);
  import lsl_pkg::*;
  localparam int PCW = $clog2(POWERUP_CYC + 1);
  localparam int LCW = $clog2(LOCK_CYC + 1);
  if (POWERUP_CYC < 1 || LOCK_CYC < 1) begin : g_chk
    $error("lsl_dev_end: cycle counts must be at least one");
  end

  // ==========================================================
  // Power-up hold-off
  logic [PCW-1:0] pwr_cnt_q;
  logic pwr_ok_q;
  wire pwr_end = pwr_cnt_q == PCW'(POWERUP_CYC - 1);
  // Counts from reset release; channel unusable until it ends
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_cnt_q <= '0;
      pwr_ok_q <= 1'b0;
    end else if (!pwr_ok_q) begin
      pwr_cnt_q <= pwr_cnt_q + PCW'(1);
      pwr_ok_q <= pwr_end;
    end
  end

  // ==========================================================
  // Lock tracking
  lsl_state_e st_q, st_d;
  logic [LCW-1:0] acq_q;
  logic [2:0] bits_q;
  wire vid_sel = lnk.video_link_on; // Video link takes precedence
  wire sig_on = vid_sel | lnk.cfg_link_on;
  wire bws_ok = lnk.ser_link_bits[LB_BWS] == bits_q[LB_BWS];
  wire edc_ok = lnk.ser_link_bits[LB_EDC] == bits_q[LB_EDC];
  wire can_lock = sig_on & bws_ok & edc_ok; // Width or correction mismatch blocks lock
  wire acq_done = acq_q == LCW'(LOCK_CYC - 1);
  // Next link state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      LSL_UNLOCKED: begin
        if (can_lock && acq_done) begin
          st_d = vid_sel ? LSL_VID_LOCKED : LSL_CFG_LOCKED;
        end
      end
      LSL_CFG_LOCKED: begin
        if (!can_lock || vid_sel) st_d = LSL_UNLOCKED; // Re-acquire on video link
      end
      LSL_VID_LOCKED: begin
        if (!can_lock || !vid_sel) st_d = LSL_UNLOCKED;
      end
      default: st_d = LSL_UNLOCKED;
    endcase
  end
  // Lock acquisition counter and state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= LSL_UNLOCKED;
      acq_q <= '0;
    end else begin
      st_q <= st_d;
      acq_q <= (st_q == LSL_UNLOCKED && can_lock && !acq_done) ? acq_q + LCW'(1) : '0;
    end
  end

  // ==========================================================
  // Control channel registers
  logic avail_q;
  logic [7:0] misc_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic lost_q;
  wire my_acc = lnk.ctl_tgt == TGT_DES && avail_q;
  wire wr_hit = lnk.ctl_wr & my_acc;
  wire rd_hit = lnk.ctl_rd & my_acc;
  wire wr_link = wr_hit && lnk.ctl_addr == ADDR_LINK;
  wire wr_misc = wr_hit && lnk.ctl_addr == ADDR_MISC;
  wire rd_stat = rd_hit && lnk.ctl_addr == ADDR_STATUS;
  wire lost_ev = st_q != LSL_UNLOCKED && st_d == LSL_UNLOCKED;
  wire [7:0] stat_word = 8'h00 | (8'(pwr_ok_q) << ST_PWR_OK) | (8'(lost_q) << ST_LOST) | 8'(st_q);
  wire [7:0] rd_mux = (lnk.ctl_addr == ADDR_LINK) ? {5'h00, bits_q} :
                      (lnk.ctl_addr == ADDR_MISC) ? misc_q :
                      (lnk.ctl_addr == ADDR_STATUS) ? stat_word : 8'h00;
  // Channel usable only after hold-off and with a link locked
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) avail_q <= 1'b0;
    else avail_q <= pwr_ok_q && st_d != LSL_UNLOCKED;
  end
  // Defaults from reset; writes apply only over a usable channel
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bits_q <= LINK_BITS_RST;
      misc_q <= MISC_RST;
    end else begin
      if (wr_link) bits_q <= lnk.ctl_wdata[2:0]; // May drop lock until serializer matches
      if (wr_misc) misc_q <= lnk.ctl_wdata;
    end
  end
  // Acknowledge and read data, one cycle after the request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= wr_hit | rd_hit;
      rdata_q <= rd_hit ? rd_mux : 8'h00;
    end
  end
  // Sticky loss-of-lock; a loss in the clearing cycle wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) lost_q <= 1'b0;
    else if (lost_ev) lost_q <= 1'b1;
    else if (rd_stat) lost_q <= 1'b0;
  end
  assign lnk.des_ack = ack_q;
  assign lnk.des_rdata = rdata_q;
  assign lnk.ctl_avail = avail_q;

  // ==========================================================
  // Outputs, all registered
  logic lock_q;
  logic deser_q;
  lsl_state_e state_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_q <= 1'b0;
      deser_q <= 1'b0;
      state_q <= LSL_UNLOCKED;
    end else begin
      lock_q <= st_d == LSL_VID_LOCKED; // Never for configuration link
      deser_q <= st_d == LSL_VID_LOCKED; // Deserialize once video locked
      state_q <= st_d;
    end
  end
  assign lnk.lock = lock_q;
  assign deser_en = deser_q;
  assign link_state = state_q;
  assign link_bits = bits_q;
  assign misc_cfg = misc_q;
  assign lock_lost = lost_q;
endmodule : lsl_dev_end
`default_nettype wire

// ### rtl/lsl_host_end.sv
// Host end: serializer register model plus the microcontroller startup sequence.
// Assumes the deserializer end on the same lsl_if and the same clock.
`timescale 1ns/1ps
`default_nettype none
module lsl_host_end #(
  parameter int LINK_WAIT = lsl_pkg::LINK_WAIT_CYCLES,
  parameter int ACK_WAIT = lsl_pkg::ACK_WAIT_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  lsl_if.host lnk,
  input wire logic start,
  input wire logic sensing_mode,
  input wire logic [2:0] target_bits,
  input wire logic [7:0] target_misc,
  output logic busy,
  output logic done,
  output logic nack_seen
);
  import lsl_pkg::*;
  localparam int WCW = $clog2((LINK_WAIT > ACK_WAIT ? LINK_WAIT : ACK_WAIT) + 1);
  if (LINK_WAIT < 1 || ACK_WAIT < 1) begin : g_chk
    $error("lsl_host_end: wait counts must be at least one");
  end

  typedef enum logic [3:0] {
    H_IDLE, H_CFG_EN, H_DES_BIT, H_SER_BIT, H_DES_REST, H_SER_REST, H_VID_EN, H_ACK, H_WAIT, H_DONE
  } lsl_hst_e;

  // ==========================================================
  // Serializer model
  logic boot_q;
  logic sens_q;
  logic cfg_en_q;
  logic ser_en_q;
  logic [2:0] ser_bits_q;
  logic [7:0] ser_misc_q;
  logic ser_ack_q;
  wire ser_wr = lnk.ctl_wr & (lnk.ctl_tgt == TGT_SER);
  wire ser_reach = ~sens_q | lnk.ctl_avail; // Sensing: serializer answers only over a live link; its writes apply regardless
  // Strap caught after reset release; sensing serializer starts video itself
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      boot_q <= 1'b0;
      sens_q <= 1'b0;
      cfg_en_q <= 1'b0;
      ser_en_q <= 1'b0;
      ser_bits_q <= LINK_BITS_RST;
      ser_misc_q <= MISC_RST;
      ser_ack_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
      ser_ack_q <= ser_wr & ser_reach;
      if (!boot_q) begin
        sens_q <= sensing_mode;
        ser_en_q <= sensing_mode;
      end else if (ser_wr) begin
        if (lnk.ctl_addr == ADDR_LINK) ser_bits_q <= lnk.ctl_wdata[2:0];
        if (lnk.ctl_addr == ADDR_MISC) ser_misc_q <= lnk.ctl_wdata;
        if (lnk.ctl_addr == ADDR_SER_EN) begin
          cfg_en_q <= lnk.ctl_wdata[EN_CFG];
          ser_en_q <= lnk.ctl_wdata[EN_SER];
        end
      end
    end
  end
  // Video link overrides configuration link
  assign lnk.cfg_link_on = cfg_en_q & ~ser_en_q;
  assign lnk.video_link_on = ser_en_q;
  assign lnk.ser_link_bits = ser_bits_q;

  // ==========================================================
  // Controller sequence
  lsl_hst_e st_q, st_d, ret_q, ret_d, aft_q, aft_d;
  logic [WCW-1:0] cnt_q;
  logic [1:0] idx_q;
  logic [2:0] acc_q;
  logic wr_q, tgt_q, tgt_d, iss;
  logic [1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  wire [2:0] acc_set = acc_q | (target_bits & (3'h1 << idx_q));
  wire ack_in = lnk.des_ack | ser_ack_q;
  wire ack_to = cnt_q == WCW'(ACK_WAIT - 1);
  wire wait_end = cnt_q == WCW'(LINK_WAIT - 1);
  // Next state; each step issues one write and waits for its answer
  always_comb begin
    st_d = st_q;
    ret_d = ret_q;
    aft_d = aft_q;
    iss = 1'b0;
    tgt_d = TGT_SER;
    addr_d = ADDR_LINK;
    data_d = 8'h00;
    unique case (st_q)
      H_IDLE: if (start) st_d = sensing_mode ? H_DES_BIT : H_CFG_EN;
      H_CFG_EN: begin // Enable configuration link, then wait
        iss = 1'b1;
        addr_d = ADDR_SER_EN;
        data_d = 8'h01 << EN_CFG;
        ret_d = H_WAIT;
        aft_d = H_DES_BIT;
      end
      H_DES_BIT: begin // Deserializer bit first
        iss = 1'b1;
        tgt_d = TGT_DES;
        data_d = {5'h00, acc_set};
        ret_d = H_SER_BIT;
      end
      H_SER_BIT: begin // Matching serializer bit, then wait
        iss = 1'b1;
        data_d = {5'h00, acc_q};
        ret_d = H_WAIT;
        aft_d = (idx_q == 2'h2) ? H_DES_REST : H_DES_BIT;
      end
      H_DES_REST: begin // Remaining bits only after link bits
        iss = 1'b1;
        tgt_d = TGT_DES;
        addr_d = ADDR_MISC;
        data_d = target_misc;
        ret_d = H_SER_REST;
      end
      H_SER_REST: begin
        iss = 1'b1;
        addr_d = ADDR_MISC;
        data_d = target_misc;
        ret_d = H_VID_EN;
      end
      H_VID_EN: begin // Start video and wait for it
        iss = 1'b1;
        addr_d = ADDR_SER_EN;
        data_d = 8'h01 << EN_SER;
        ret_d = H_WAIT;
        aft_d = H_DONE;
      end
      H_ACK: if (ack_in || ack_to) st_d = ret_q; // Missing answer tolerated
      H_WAIT: if (wait_end) st_d = aft_q;
      H_DONE: st_d = H_IDLE;
      default: st_d = H_IDLE;
    endcase
    if (iss) st_d = H_ACK;
  end
  // Sequence registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= H_IDLE;
      ret_q <= H_IDLE;
      aft_q <= H_IDLE;
      cnt_q <= '0;
      idx_q <= 2'h0;
      acc_q <= LINK_BITS_RST;
      wr_q <= 1'b0;
      tgt_q <= TGT_SER;
      addr_q <= ADDR_LINK;
      data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      ret_q <= ret_d;
      aft_q <= aft_d;
      wr_q <= iss;
      tgt_q <= tgt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      cnt_q <= (st_d == st_q && (st_q == H_ACK || st_q == H_WAIT)) ? cnt_q + WCW'(1) : '0;
      if (st_q == H_IDLE && start) begin
        acc_q <= sensing_mode ? target_bits : LINK_BITS_RST;
        idx_q <= sensing_mode ? 2'h2 : 2'h0;
      end
      if (st_q == H_DES_BIT) acc_q <= acc_set;
      if (st_q == H_SER_BIT && idx_q != 2'h2) idx_q <= idx_q + 2'h1;
    end
  end
  assign lnk.ctl_wr = wr_q;
  assign lnk.ctl_rd = 1'b0;
  assign lnk.ctl_tgt = tgt_q;
  assign lnk.ctl_addr = addr_q;
  assign lnk.ctl_wdata = data_q;
  // User status
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      nack_seen <= 1'b0;
    end else begin
      busy <= st_d != H_IDLE;
      done <= st_q == H_DONE;
      if (st_q == H_IDLE && start) nack_seen <= 1'b0;
      else if (st_q == H_ACK && ack_to && !ack_in) nack_seen <= 1'b1;
    end
  end
endmodule : lsl_host_end
`default_nettype wire

// ### shared/lsl_if.sv
// Interface: serial link and control channel between deserializer end and host end.
// Assumes both ends share clock and resetn; the testbench instantiates it.
`timescale 1ns/1ps
`default_nettype none
interface lsl_if (
  input wire logic clock,
  input wire logic resetn
);
  logic cfg_link_on;
  logic video_link_on;
  logic [2:0] ser_link_bits;
  logic ctl_wr;
  logic ctl_rd;
  logic ctl_tgt;
  logic [1:0] ctl_addr;
  logic [7:0] ctl_wdata;
  logic des_ack;
  logic [7:0] des_rdata;
  logic ctl_avail;
  logic lock;
  modport dev (
    input cfg_link_on, video_link_on, ser_link_bits, ctl_wr, ctl_rd, ctl_tgt, ctl_addr, ctl_wdata,
    output des_ack, des_rdata, ctl_avail, lock
  );
  modport host (
    output cfg_link_on, video_link_on, ser_link_bits, ctl_wr, ctl_rd, ctl_tgt, ctl_addr, ctl_wdata,
    input des_ack, des_rdata, ctl_avail, lock
  );
endinterface : lsl_if
`default_nettype wire

// ### shared/lsl_pkg.sv
// Package: constants and types shared by both ends of the link startup sequencer.
// Assumes a single 100 MHz clock common to both ends.
`default_nettype none
package lsl_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int POWERUP_MS = 2;
  localparam int POWERUP_CYCLES = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int LINK_WAIT_MS = 3;
  localparam int LINK_WAIT_CYCLES = LINK_WAIT_MS * 1000 * CLK_MHZ;
  localparam int LOCK_ACQ_US = 1;
  localparam int LOCK_ACQ_CYCLES = LOCK_ACQ_US * CLK_MHZ;
  localparam int ACK_WAIT_CYCLES = 64;
  // ==========================================================
  // Control channel targets and register offsets
  localparam logic TGT_DES = 1'b0;
  localparam logic TGT_SER = 1'b1;
  localparam logic [1:0] ADDR_LINK = 2'h0;
  localparam logic [1:0] ADDR_MISC = 2'h1;
  localparam logic [1:0] ADDR_SER_EN = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // ==========================================================
  // Field positions
  localparam int LB_DRS = 0;
  localparam int LB_BWS = 1;
  localparam int LB_EDC = 2;
  localparam int EN_CFG = 0;
  localparam int EN_SER = 1;
  localparam int ST_PWR_OK = 2;
  localparam int ST_LOST = 3;
  // ==========================================================
  // Reset values
  localparam logic [2:0] LINK_BITS_RST = 3'h0;
  localparam logic [7:0] MISC_RST = 8'h00;
  // ==========================================================
  // Link state
  typedef enum logic [1:0] {LSL_UNLOCKED, LSL_CFG_LOCKED, LSL_VID_LOCKED} lsl_state_e;
endpackage : lsl_pkg
`default_nettype wire

// ### tb/lsl_link_asserts.sv
// Checker: timing relations on the link and control channel between the two ends.
// Assumes one clock domain; instantiated beside the interface by tb_top.
`timescale 1ns/1ps
`default_nettype none
module lsl_link_asserts
  import lsl_pkg::*;
#(
  parameter int POWERUP_CYC = 20,
  parameter int LOCK_CYC = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_link_on,
  input wire logic video_link_on,
  input wire logic [2:0] ser_link_bits,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic ctl_tgt,
  input wire logic [1:0] ctl_addr,
  input wire logic [7:0] ctl_wdata,
  input wire logic des_ack,
  input wire logic [7:0] des_rdata,
  input wire logic ctl_avail,
  input wire logic lock
);
  localparam int ACQ_MAX = LOCK_CYC + 4;
  logic [31:0] up_cnt_q;
  logic [31:0] up_cnt_d;
  // ==========================================================
  // Cycles since reset release, saturating
  assign up_cnt_d = (up_cnt_q == 32'hffffffff) ? up_cnt_q : up_cnt_q + 32'h1;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) up_cnt_q <= 32'h0;
    else up_cnt_q <= up_cnt_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Properties
  property p_lock_video; lock |-> $past(video_link_on, 3); endproperty
  a_lock_video: assert property (p_lock_video) else $error("lock without video link");
  property p_avail_link; ctl_avail |-> ($past(cfg_link_on, 3) || $past(video_link_on, 3)); endproperty
  a_avail_link: assert property (p_avail_link) else $error("channel usable without link");
  property p_powerup; ctl_avail |-> up_cnt_q >= POWERUP_CYC - 1; endproperty
  a_powerup: assert property (p_powerup) else $error("channel usable during hold-off");
  property p_ack_cause;
    des_ack |-> $past(ctl_wr || ctl_rd) && ($past(ctl_tgt) == TGT_DES) && $past(ctl_avail);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without access");
  property p_ack_iff; (ctl_wr || ctl_rd) && (ctl_tgt == TGT_DES) |=> des_ack == $past(ctl_avail); endproperty
  a_ack_iff: assert property (p_ack_iff) else $error("acknowledge not as channel state");
  property p_rdata_idle; !$past(ctl_rd) |-> des_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_lock_src; $rose(lock) |-> $past(video_link_on, LOCK_CYC) && video_link_on; endproperty
  a_lock_src: assert property (p_lock_src) else $error("lock too early");
  property p_vid_drop; $rose(video_link_on) |-> ##[1:3] !ctl_avail; endproperty
  a_vid_drop: assert property (p_vid_drop) else $error("config lock kept under video");
  property p_cfg_lock; $rose(cfg_link_on) && (up_cnt_q > POWERUP_CYC) |-> ##[1:ACQ_MAX] ctl_avail; endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("no config lock");
  property p_vid_lock; $rose(video_link_on) |-> ##[1:ACQ_MAX] lock; endproperty
  a_vid_lock: assert property (p_vid_lock) else $error("no video lock");
  // Main scenarios
  c_vid_lock: cover property ($rose(lock));
  c_cfg_avail: cover property (ctl_avail && cfg_link_on);
  c_ack: cover property (des_ack);
  c_refused: cover property ((ctl_wr || ctl_rd) && !ctl_avail && (ctl_tgt == TGT_DES));
endmodule : lsl_link_asserts
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: both ends joined, plus a second device end driven directly.
// Assumes shortened counts on every instance; expectations use the same values.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lsl_pkg::*;
  localparam int PWR = 20;
  localparam int LCK = 4;
  typedef struct packed {logic sense; logic [2:0] bits; logic [7:0] misc; logic nack;} lsl_row_s;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic sensing_mode = 1'b0;
  logic [2:0] target_bits = 3'h0;
  logic [7:0] target_misc = 8'h00;
  logic busy, done, nack_seen, deser_en, lock_lost, deser_en2, lock_lost2, ack, got;
  logic [2:0] link_bits, link_bits2;
  logic [7:0] misc_cfg, misc_cfg2, rdat;
  lsl_state_e link_state, link_state2;
  int err_total = 0;
  int comparisons = 0;
  // Sensing rows change width or correction, so the serializer write goes unanswered
  lsl_row_s rows [5] = '{'{1'b0, 3'h0, 8'h00, 1'b0}, '{1'b0, 3'h7, 8'ha5, 1'b0}, '{1'b0, 3'h1, 8'h3c, 1'b0},
                         '{1'b1, 3'h7, 8'h5a, 1'b1}, '{1'b1, 3'h6, 8'hff, 1'b1}};
  // ==========================================================
  // Clock, ends and checker
  always #5 clock = ~clock;
  lsl_if lnk (.clock(clock), .resetn(resetn));
  lsl_if lnk2 (.clock(clock), .resetn(resetn));
  lsl_host_end #(.LINK_WAIT(50), .ACK_WAIT(8)) lsl_host_end_i (.clock(clock), .resetn(resetn), .lnk(lnk),
    .start(start), .sensing_mode(sensing_mode), .target_bits(target_bits), .target_misc(target_misc),
    .busy(busy), .done(done), .nack_seen(nack_seen));
  lsl_dev_end #(.POWERUP_CYC(PWR), .LOCK_CYC(LCK)) lsl_dev_end_i (.clock(clock), .resetn(resetn), .lnk(lnk),
    .link_state(link_state), .deser_en(deser_en), .link_bits(link_bits), .misc_cfg(misc_cfg),
    .lock_lost(lock_lost));
  lsl_dev_end #(.POWERUP_CYC(PWR), .LOCK_CYC(LCK)) lsl_dev_end_b_i (.clock(clock), .resetn(resetn),
    .lnk(lnk2), .link_state(link_state2), .deser_en(deser_en2), .link_bits(link_bits2),
    .misc_cfg(misc_cfg2), .lock_lost(lock_lost2));
  lsl_link_asserts #(.POWERUP_CYC(PWR), .LOCK_CYC(LCK)) lsl_link_asserts_i (.clock(clock), .resetn(resetn),
    .cfg_link_on(lnk.cfg_link_on), .video_link_on(lnk.video_link_on), .ser_link_bits(lnk.ser_link_bits),
    .ctl_wr(lnk.ctl_wr), .ctl_rd(lnk.ctl_rd), .ctl_tgt(lnk.ctl_tgt), .ctl_addr(lnk.ctl_addr),
    .ctl_wdata(lnk.ctl_wdata), .des_ack(lnk.des_ack), .des_rdata(lnk.des_rdata),
    .ctl_avail(lnk.ctl_avail), .lock(lnk.lock));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    #1;
  endtask : do_reset
  // One control-channel access on the second link; answer taken in the next cycle
  task automatic acc(input logic rd, input logic tgt, input logic [1:0] a, input logic [7:0] d);
    lnk2.ctl_rd <= rd;
    lnk2.ctl_wr <= ~rd;
    lnk2.ctl_tgt <= tgt;
    lnk2.ctl_addr <= a;
    lnk2.ctl_wdata <= d;
    @(posedge clock);
    lnk2.ctl_rd <= 1'b0;
    lnk2.ctl_wr <= 1'b0;
    #1;
    ack = lnk2.des_ack;
    rdat = lnk2.des_rdata;
  endtask : acc
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  // ==========================================================
  // Sequences
  initial begin
    lnk2.cfg_link_on = 1'b0;
    lnk2.video_link_on = 1'b0;
    lnk2.ser_link_bits = 3'h0;
    lnk2.ctl_wr = 1'b0;
    lnk2.ctl_rd = 1'b0;
    lnk2.ctl_tgt = 1'b0;
    lnk2.ctl_addr = 2'h0;
    lnk2.ctl_wdata = 8'h00;
    // Full startups in both application modes
    for (int r = 0; r < 5; r++) begin
      sensing_mode <= rows[r].sense;
      target_bits <= rows[r].bits;
      target_misc <= rows[r].misc;
      do_reset();
      tick(PWR + 20);
      start <= 1'b1;
      tick(1);
      start <= 1'b0;
      chk("busy", {7'h0, busy}, 8'h01);
      got = 1'b0;
      for (int i = 0; i < 3000 && got !== 1'b1; i++) begin
        tick(1);
        got = done;
      end
      chk("done", {7'h0, got}, 8'h01);
      chk("link_bits", {5'h0, link_bits}, {5'h0, rows[r].bits});
      chk("misc_cfg", misc_cfg, rows[r].misc);
      chk("lock", {7'h0, lnk.lock}, 8'h01);
      chk("deser_en", {7'h0, deser_en}, 8'h01);
      chk("link_state", {6'h0, link_state}, {6'h0, LSL_VID_LOCKED});
      chk("nack_seen", {7'h0, nack_seen}, {7'h0, rows[r].nack});
      chk("busy_end", {7'h0, busy}, 8'h00);
      chk("lock_lost", {7'h0, lock_lost}, 8'h01); // Every row drops lock at least once
    end
    // Hold-off, defaults, unmapped place, loss and relock, video takeover
    lnk2.cfg_link_on <= 1'b1;
    do_reset();
    tick(LCK + 4);
    chk("state_b", {6'h0, link_state2}, {6'h0, LSL_CFG_LOCKED});
    chk("avail_early", {7'h0, lnk2.ctl_avail}, 8'h00);
    acc(1'b0, TGT_DES, ADDR_MISC, 8'h77);
    chk("ack_early", {7'h0, ack}, 8'h00);
    chk("misc_b", misc_cfg2, MISC_RST);
    tick(PWR);
    chk("avail", {7'h0, lnk2.ctl_avail}, 8'h01);
    chk("lock_cfg", {7'h0, lnk2.lock}, 8'h00);
    acc(1'b1, TGT_DES, ADDR_MISC, 8'h00);
    chk("misc_dflt", rdat, MISC_RST);
    acc(1'b1, TGT_DES, ADDR_LINK, 8'h00);
    chk("link_dflt", rdat, {5'h0, LINK_BITS_RST});
    acc(1'b1, TGT_DES, ADDR_SER_EN, 8'h00);
    chk("unmapped_ack", {7'h0, ack}, 8'h01);
    chk("unmapped_rd", rdat, 8'h00);
    acc(1'b0, TGT_DES, ADDR_STATUS, 8'hff);
    acc(1'b1, TGT_DES, ADDR_STATUS, 8'h00);
    chk("status", rdat, 8'h05);
    acc(1'b0, TGT_DES, ADDR_LINK, 8'h02);
    tick(3);
    chk("state_lost", {6'h0, link_state2}, {6'h0, LSL_UNLOCKED});
    chk("avail_lost", {7'h0, lnk2.ctl_avail}, 8'h00);
    chk("lost_b", {7'h0, lock_lost2}, 8'h01);
    lnk2.ser_link_bits <= 3'h2;
    tick(LCK + 4);
    chk("state_relock", {6'h0, link_state2}, {6'h0, LSL_CFG_LOCKED});
    chk("link_bits_b", {5'h0, link_bits2}, 8'h02);
    acc(1'b1, TGT_DES, ADDR_STATUS, 8'h00);
    chk("status_lost", rdat, 8'h0d);
    acc(1'b1, TGT_DES, ADDR_STATUS, 8'h00);
    chk("status_clr", rdat, 8'h05);
    chk("lost_clr", {7'h0, lock_lost2}, 8'h00);
    acc(1'b0, TGT_SER, ADDR_LINK, 8'h00);
    chk("ack_ser", {7'h0, ack}, 8'h00);
    lnk2.cfg_link_on <= 1'b0;
    lnk2.video_link_on <= 1'b1;
    tick(2);
    chk("avail_vid", {7'h0, lnk2.ctl_avail}, 8'h00);
    chk("lock_pre", {7'h0, lnk2.lock}, 8'h00);
    tick(LCK + 4);
    chk("lock_vid", {7'h0, lnk2.lock}, 8'h01);
    chk("deser_b", {7'h0, deser_en2}, 8'h01);
    chk("avail_v", {7'h0, lnk2.ctl_avail}, 8'h01);
    lnk2.video_link_on <= 1'b0;
    tick(3);
    chk("lock_off", {7'h0, lnk2.lock}, 8'h00);
    chk("state_off", {6'h0, link_state2}, {6'h0, LSL_UNLOCKED});
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
